// ---- hdl/trap_vec_params.svh ----
`ifndef TRAP_VEC_PARAMS_SVH
`define TRAP_VEC_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define OFS_TRAP_FLAGS    12'h000
`define OFS_IRQ_STATUS    12'h004
`define OFS_IRQ_MASK      12'h008
`define OFS_CORE_STATUS   12'h00C
`define OFS_SRC_BASE_PAGE 4'h1

// Peripheral sources: source i owns trap number SRC_FIRST_TRAP + i.
`define NUM_SOURCES       56
`define SRC_FIRST_TRAP    7'h10

// Fixed trap numbers.
`define TRAP_RESET        7'h00
`define TRAP_NMI          7'h02
`define TRAP_STACK_OVER   7'h04
`define TRAP_STACK_UNDER  7'h06
`define TRAP_CLASS_B      7'h0A

// Source control word fields.
`define CTL_LVL_LSB       0
`define CTL_LVL_MSB       3
`define CTL_EN_BIT        6
`define CTL_REQ_BIT       7

// Trap flag bit positions.
`define TF_NMI            0
`define TF_STACK_OVER     1
`define TF_STACK_UNDER    2
`define TF_CLASS_B_LSB    3
`define NUM_TRAP_FLAGS    8

// Interrupt status bit positions.
`define IS_CLASS_A        0
`define IS_CLASS_B        1
`define IS_RESET_FN       2
`define IS_SW_TRAP        3
`define NUM_IRQ_BITS      4

// Trap service priorities and reset values.
`define PRIO_NONE         2'h0
`define PRIO_CLASS_B      2'h1
`define PRIO_CLASS_A      2'h2
`define RST_IRQ_MASK      4'h0
`define RST_LEVEL         4'h0
`define TRAP_LEVEL        4'hF

// AXI responses.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- hdl/trap_vec_pkg.sv ----
package trap_vec_pkg;

	typedef enum logic [1:0] {
		EVT_RESET  = 2'b00,
		EVT_TRAP   = 2'b01,
		EVT_SWTRAP = 2'b10,
		EVT_INT    = 2'b11
	} evt_kind_e;

	// Exception strobes from the core, one cycle each.
	typedef struct packed {
		logic stack_overflow_flag;
		logic stack_underflow_flag;
		logic undefined_opcode_flag;
		logic protected_instruction_fault_flag;
		logic illegal_operand_access_flag;
		logic illegal_instruction_access_flag;
		logic illegal_bus_access_flag;
	} hw_trap_s;

	// Vectoring order handed to the core.
	typedef struct packed {
		evt_kind_e   kind;
		logic [6:0]  num;
		logic [8:0]  vector;
		logic [3:0]  level;
		logic [5:0]  src;
	} evt_s;

endpackage

// ---- hdl/interrupt_trap_vectoring.sv ----
// Functional notes
// - Each source has request flag, enable flag, vector location and trap number.
// - Sources vector per the map, e.g. trap 46h at 118h, 20h at 80h.
// - Run-time exceptions raise hardware traps independent of request flags.
// - Hardware traps cannot be masked and branch to their own vector.
// - Every hardware trap sets its own bit in the trap flag register.
// - A hardware trap preempts anything except a pending reset or a trap service of equal or higher priority.
// - Standard interrupts and transfers do not break into a trap service.
// - NMI 08h/02h, stack overflow 10h/04h, stack underflow 18h/06h.
// - All class B traps share 28h/0Ah; flags tell the cause apart.
// - Hardware reset, software reset and watchdog overflow go to 0000h/00h.
// - Software trap takes any number 00h-7Fh, keeps current CPU priority.
// - Software sets one of sixteen priority levels per source.
// - A service is interrupted only by a strictly higher priority request.
`timescale 1ns/10ps
`include "trap_vec_params.svh"

module interrupt_trap_vectoring
	import trap_vec_pkg::*;
#(
	parameter int NSRC = `NUM_SOURCES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [NSRC-1:0]   src_req,
	input  wire logic              nmi_pin_n,
	input  wire hw_trap_s          hw_trap,
	input  wire logic              sw_reset,
	input  wire logic              wdt_overflow,
	input  wire logic              sw_trap_valid,
	input  wire logic [6:0]        sw_trap_num,
	input  wire logic [3:0]        cpu_prio,
	input  wire logic              trap_done,
	output logic                   evt_valid,
	output evt_s                   evt,
	input  wire logic              evt_ack,
	output logic                   irq
);

	logic [3:0]                    lvl_r [NSRC];
	logic [3:0]                    lvl_nxt [NSRC];
	logic [NSRC-1:0]               en_r, en_nxt;
	logic [NSRC-1:0]               req_r, req_nxt;
	logic [`NUM_TRAP_FLAGS-1:0]    trap_flag_register_r;
	logic [`NUM_TRAP_FLAGS-1:0]    trap_flag_register_nxt;
	logic [`NUM_TRAP_FLAGS-1:0]    tpend_r, tpend_nxt;
	logic [`NUM_IRQ_BITS-1:0]      stat_r, stat_nxt;
	logic [`NUM_IRQ_BITS-1:0]      mask_r, mask_nxt;
	logic [1:0]                    tact_r, tact_nxt;
	logic                          rst_pend_r, rst_pend_nxt;
	logic                          swt_pend_r, swt_pend_nxt;
	logic [6:0]                    swt_num_r, swt_num_nxt;
	logic [2:0]                    nmi_s_r, nmi_s_nxt;
	logic                          nmi_lvl_r, nmi_lvl_nxt;
	logic                          evt_valid_r, evt_valid_nxt;
	evt_s                          evt_r, evt_nxt;
	logic                          aw_got_r, aw_got_nxt;
	logic                          w_got_r, w_got_nxt;
	logic [11:0]                   awaddr_r, awaddr_nxt;
	logic [31:0]                   wdata_r, wdata_nxt;
	logic                          wlane_r, wlane_nxt;
	logic                          bvalid_r, bvalid_nxt;
	logic [1:0]                    bresp_r, bresp_nxt;
	logic                          rvalid_r, rvalid_nxt;
	logic [31:0]                   rdata_r, rdata_nxt;
	logic [1:0]                    rresp_r, rresp_nxt;
	logic [`NUM_TRAP_FLAGS-1:0]    hw_set;
	logic                          nmi_evt;
	logic                          wr_do;
	logic                          rd_do;

	// Returns the source index behind an address, or NSRC when unmapped.
	function automatic int src_sel(input logic [11:0] a);
		int s;
		s = NSRC;
		if (a[11:8] == `OFS_SRC_BASE_PAGE && int'(a[7:2]) < NSRC) begin
			s = int'(a[7:2]);
		end
		return s;
	endfunction

	// Service priority of a trap flag: class A above class B.
	function automatic logic [1:0] trap_prio(input int i);
		return (i < `TF_CLASS_B_LSB) ? `PRIO_CLASS_A : `PRIO_CLASS_B;
	endfunction

	function automatic logic [6:0] trap_num(input int i);
		logic [6:0] n;
		case (i)
			`TF_NMI:   n = `TRAP_NMI;
			`TF_STACK_OVER: n = `TRAP_STACK_OVER;
			`TF_STACK_UNDER: n = `TRAP_STACK_UNDER;
			default:   n = `TRAP_CLASS_B;
		endcase
		return n;
	endfunction

	// Vector location is the trap number times four.
	function automatic logic [8:0] vec_of(input logic [6:0] n);
		return {n, 2'b00};
	endfunction

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign evt_valid     = evt_valid_r;
	assign evt           = evt_r;
	assign irq           = |(stat_r & mask_r);
	assign wr_do         = aw_got_r & w_got_r & ~bvalid_r;
	assign rd_do         = s_axi_arvalid & ~rvalid_r;

	// The pin passes three flops; a change counts once stages two and
	// three agree, which also rejects a single-cycle glitch.
	assign nmi_evt = nmi_lvl_r & (nmi_s_r[1] == nmi_s_r[2]) & ~nmi_s_r[1];
	assign hw_set  = {hw_trap.illegal_bus_access_flag,
		hw_trap.illegal_instruction_access_flag,
		hw_trap.illegal_operand_access_flag,
		hw_trap.protected_instruction_fault_flag,
		hw_trap.undefined_opcode_flag,
		hw_trap.stack_underflow_flag,
		hw_trap.stack_overflow_flag,
		nmi_evt};

	always_comb begin
		int   sel;
		int   best;
		int   tsel;
		logic [3:0] best_lvl;
		sel = 0;
		best = NSRC;
		tsel = `NUM_TRAP_FLAGS;
		best_lvl = cpu_prio;
		lvl_nxt = lvl_r;
		en_nxt = en_r;
		req_nxt = req_r;
		trap_flag_register_nxt = trap_flag_register_r;
		tpend_nxt = tpend_r;
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		tact_nxt = tact_r;
		rst_pend_nxt = rst_pend_r;
		swt_pend_nxt = swt_pend_r;
		swt_num_nxt = swt_num_r;
		evt_valid_nxt = evt_valid_r;
		evt_nxt = evt_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wlane_nxt = wlane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		nmi_s_nxt = {nmi_s_r[1:0], nmi_pin_n};
		nmi_lvl_nxt = (nmi_s_r[1] == nmi_s_r[2]) ? nmi_s_r[1] : nmi_lvl_r;

		// Highest enabled level strictly above the CPU level wins; ties go
		// to the lower trap number.
		for (int i = 0; i < NSRC; i++) begin
			if (req_r[i] && en_r[i] && lvl_r[i] > best_lvl) begin
				best_lvl = lvl_r[i];
				best = i;
			end
		end
		for (int i = `NUM_TRAP_FLAGS - 1; i >= 0; i--) begin
			if (tpend_r[i] && trap_prio(i) > tact_r) begin
				tsel = i;
			end
		end

		if (trap_done) begin
			tact_nxt = `PRIO_NONE;
		end

		// The order is held until taken, so the core sees stable data.
		if (!evt_valid_r) begin
			if (rst_pend_r) begin
				evt_valid_nxt = 1'b1;
				evt_nxt = '{EVT_RESET, `TRAP_RESET, vec_of(`TRAP_RESET),
					`RST_LEVEL, 6'h00};
			end else if (tsel < `NUM_TRAP_FLAGS) begin
				evt_valid_nxt = 1'b1;
				evt_nxt = '{EVT_TRAP, trap_num(tsel), vec_of(trap_num(tsel)),
					`TRAP_LEVEL, 6'(tsel)};
			end else if (swt_pend_r) begin
				evt_valid_nxt = 1'b1;
				evt_nxt = '{EVT_SWTRAP, swt_num_r, vec_of(swt_num_r),
					cpu_prio, 6'h00};
			end else if (best < NSRC && tact_r == `PRIO_NONE) begin
				evt_valid_nxt = 1'b1;
				evt_nxt = '{EVT_INT, 7'(int'(`SRC_FIRST_TRAP) + best),
					vec_of(7'(int'(`SRC_FIRST_TRAP) + best)),
					best_lvl, 6'(best)};
			end
		end else if (evt_ack) begin
			evt_valid_nxt = 1'b0;
			case (evt_r.kind)
				EVT_RESET: begin
					rst_pend_nxt = 1'b0;
					tact_nxt = `PRIO_NONE;
				end
				EVT_TRAP: begin
					tact_nxt = trap_prio(int'(evt_r.src));
					if (evt_r.src < 6'(`TF_CLASS_B_LSB)) begin
						tpend_nxt[evt_r.src[2:0]] = 1'b0;
					end else begin
						tpend_nxt[`NUM_TRAP_FLAGS-1:`TF_CLASS_B_LSB] = '0;
					end
				end
				EVT_SWTRAP: swt_pend_nxt = 1'b0;
				EVT_INT: req_nxt[evt_r.src] = 1'b0;
				default: evt_valid_nxt = 1'b0;
			endcase
		end

		// Write path: address and data may arrive in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wlane_nxt = s_axi_wstrb[0];
		end
		if (wr_do) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = `RESP_OKAY;
			sel = src_sel(awaddr_r);
			if (sel < NSRC) begin
				if (wlane_r) begin
					lvl_nxt[sel] = wdata_r[`CTL_LVL_MSB:`CTL_LVL_LSB];
					en_nxt[sel] = wdata_r[`CTL_EN_BIT];
					req_nxt[sel] = wdata_r[`CTL_REQ_BIT];
				end
			end else if (awaddr_r == `OFS_TRAP_FLAGS) begin
				if (wlane_r) begin
					trap_flag_register_nxt = trap_flag_register_r &
						~wdata_r[`NUM_TRAP_FLAGS-1:0];
				end
			end else if (awaddr_r == `OFS_IRQ_MASK) begin
				if (wlane_r) begin
					mask_nxt = wdata_r[`NUM_IRQ_BITS-1:0];
				end
			end else if (awaddr_r != `OFS_IRQ_STATUS &&
				awaddr_r != `OFS_CORE_STATUS) begin
				bresp_nxt = `RESP_SLVERR;
			end
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end

		// Read path; reading the status word clears it.
		if (rd_do) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			sel = src_sel(s_axi_araddr);
			if (sel < NSRC) begin
				rdata_nxt[`CTL_LVL_MSB:`CTL_LVL_LSB] = lvl_r[sel];
				rdata_nxt[`CTL_EN_BIT] = en_r[sel];
				rdata_nxt[`CTL_REQ_BIT] = req_r[sel];
			end else begin
				case (s_axi_araddr)
					`OFS_TRAP_FLAGS:
						rdata_nxt[`NUM_TRAP_FLAGS-1:0] = trap_flag_register_r;
					`OFS_IRQ_STATUS: begin
						rdata_nxt[`NUM_IRQ_BITS-1:0] = stat_r;
						stat_nxt = '0;
					end
					`OFS_IRQ_MASK:
						rdata_nxt[`NUM_IRQ_BITS-1:0] = mask_r;
					`OFS_CORE_STATUS:
						rdata_nxt[4:0] = {swt_pend_r, evt_valid_r, tact_r,
							rst_pend_r};
					default: rresp_nxt = `RESP_SLVERR;
				endcase
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end

		// Hardware sets come last so they win over any clear this cycle.
		req_nxt = req_nxt | src_req;
		trap_flag_register_nxt = trap_flag_register_nxt | hw_set;
		tpend_nxt = tpend_nxt | hw_set;
		if (sw_reset || wdt_overflow) begin
			rst_pend_nxt = 1'b1;
			stat_nxt[`IS_RESET_FN] = 1'b1;
		end
		if (sw_trap_valid) begin
			swt_pend_nxt = 1'b1;
			swt_num_nxt = sw_trap_num;
			stat_nxt[`IS_SW_TRAP] = 1'b1;
		end
		if (|hw_set[`TF_STACK_UNDER:`TF_NMI]) begin
			stat_nxt[`IS_CLASS_A] = 1'b1;
		end
		if (|hw_set[`NUM_TRAP_FLAGS-1:`TF_CLASS_B_LSB]) begin
			stat_nxt[`IS_CLASS_B] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NSRC; i++) begin
				lvl_r[i] <= `RST_LEVEL;
			end
			en_r <= '0;
			req_r <= '0;
			trap_flag_register_r <= '0;
			tpend_r <= '0;
			stat_r <= '0;
			mask_r <= `RST_IRQ_MASK;
			tact_r <= `PRIO_NONE;
			rst_pend_r <= 1'b1;
			swt_pend_r <= 1'b0;
			swt_num_r <= 7'h00;
			nmi_s_r <= 3'h7;
			nmi_lvl_r <= 1'b1;
			evt_valid_r <= 1'b0;
			evt_r <= '0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wlane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else begin
			lvl_r <= lvl_nxt;
			en_r <= en_nxt;
			req_r <= req_nxt;
			trap_flag_register_r <= trap_flag_register_nxt;
			tpend_r <= tpend_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			tact_r <= tact_nxt;
			rst_pend_r <= rst_pend_nxt;
			swt_pend_r <= swt_pend_nxt;
			swt_num_r <= swt_num_nxt;
			nmi_s_r <= nmi_s_nxt;
			nmi_lvl_r <= nmi_lvl_nxt;
			evt_valid_r <= evt_valid_nxt;
			evt_r <= evt_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wlane_r <= wlane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

endmodule

// ---- testbench/interrupt_trap_vectoring_monitor.sv ----
`timescale 1ns/10ps
module interrupt_trap_vectoring_monitor
	import trap_vec_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [3:0] cpu_prio,
	input wire logic       trap_done,
	input wire logic       evt_valid,
	input wire evt_s       evt,
	input wire logic       evt_ack
);
	logic in_trap_r;
	logic in_trap_nxt;
	logic taken;

	assign taken = evt_valid && evt_ack;

	// Mirrors whether the core is inside a trap service.
	always_comb begin
		in_trap_nxt = in_trap_r;
		if (trap_done || (taken && evt.kind == EVT_RESET))
			in_trap_nxt = 1'b0;
		if (taken && evt.kind == EVT_TRAP)
			in_trap_nxt = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			in_trap_r <= 1'b0;
		else
			in_trap_r <= in_trap_nxt;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_vec_x4;
		evt_valid |-> evt.vector == {evt.num, 2'b00};
	endproperty
	a_vec_x4: assert property (p_vec_x4) else $error("bad vector");
	property p_hold;
		evt_valid && !evt_ack |=> evt_valid && $stable(evt);
	endproperty
	a_hold: assert property (p_hold) else $error("order dropped");
	property p_cls_a;
		evt_valid && evt.kind == EVT_TRAP && evt.src < 3
			|-> evt.num == 7'(2 * evt.src + 2);
	endproperty
	a_cls_a: assert property (p_cls_a) else $error("class A number");
	property p_cls_b;
		evt_valid && evt.kind == EVT_TRAP && evt.src > 2 |-> evt.num == 7'h0A;
	endproperty
	a_cls_b: assert property (p_cls_b) else $error("class B number");
	property p_reset;
		evt_valid && evt.kind == EVT_RESET |-> evt.num == 7'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset number");
	property p_int_map;
		evt_valid && evt.kind == EVT_INT |-> evt.num == 7'h10 + 7'(evt.src);
	endproperty
	a_int_map: assert property (p_int_map) else $error("source number");
	property p_int_prio;
		$rose(evt_valid) && evt.kind == EVT_INT |-> evt.level > $past(cpu_prio);
	endproperty
	a_int_prio: assert property (p_int_prio) else $error("low level");
	property p_sw_lvl;
		$rose(evt_valid) && evt.kind == EVT_SWTRAP
			|-> evt.level == $past(cpu_prio);
	endproperty
	a_sw_lvl: assert property (p_sw_lvl) else $error("soft level");
	property p_trap_blk;
		$rose(evt_valid) && $past(in_trap_r) |-> evt.kind != EVT_INT;
	endproperty
	a_trap_blk: assert property (p_trap_blk) else $error("int in trap");
endmodule

bind interrupt_trap_vectoring interrupt_trap_vectoring_monitor mon_i (.*);

// ---- testbench/core_partner.sv ----
`timescale 1ns/10ps
module core_partner
	import trap_vec_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       evt_valid,
	input  wire evt_s       evt,
	input  wire logic [3:0] ack_delay,
	output logic            evt_ack = 1'b0,
	output logic            trap_done = 1'b0
);
	int wait_cnt;
	int svc_cnt;

	// A core busy in a trap service leaves later orders pending, so a
	// preempting trap is seen on the port before it is taken.
	always @(posedge aclk) begin
		evt_ack <= 1'b0;
		trap_done <= 1'b0;
		if (!aresetn) begin
			wait_cnt = 0;
			svc_cnt = 0;
		end else begin
			if (evt_valid && !evt_ack && svc_cnt == 0) begin
				if (wait_cnt >= ack_delay) begin
					evt_ack <= 1'b1;
					wait_cnt = 0;
					svc_cnt = evt.kind == EVT_TRAP ? 13 : 0;
				end else begin
					wait_cnt++;
				end
			end
			if (svc_cnt > 0) begin
				svc_cnt--;
				trap_done <= svc_cnt == 0;
			end
		end
	end
endmodule

// ---- testbench/interrupt_trap_vectoring_tb_top.sv ----
`timescale 1ns/10ps
module interrupt_trap_vectoring_tb_top
	import trap_vec_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, irq, trap_done, evt_ack;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_s;
	logic [3:0]  s_axi_wstrb = 4'hF, cpu_prio = '0, ack_delay = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs_s, bs_s;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sw_reset = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, evt_valid, nmi_pin_n = 1'b1;
	logic        wdt_overflow = 1'b0, sw_trap_valid = 1'b0;
	logic [55:0] src_req = '0;
	logic [6:0]  sw_trap_num = '0;
	hw_trap_s    hw_trap = '0;
	evt_s        evt;
	evt_s        exp_q[$];
	int          errors = 0, comparisons = 0, seed = 74, i, k, n, lv;

	always #5 aclk = ~aclk;

	interrupt_trap_vectoring interrupt_trap_vectoring_i (.*);
	core_partner core_partner_i (.*);

	// Sampling at the falling edge keeps reads clear of register updates.
	always @(negedge aclk) begin
		rd_s = s_axi_rdata;
		rs_s = s_axi_rresp;
		bs_s = s_axi_bresp;
		if (aresetn && evt_valid && evt_ack)
			chk_evt(evt, exp_q.size() ? exp_q.pop_front() : evt_s'('1));
	end

	function automatic evt_s mk(evt_kind_e kd, int num, int lvl, int src);
		mk.kind = kd;
		mk.num = 7'(num);
		mk.vector = 9'(num * 4);
		mk.level = 4'(lvl);
		mk.src = 6'(src);
	endfunction

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_evt(input evt_s g, input evt_s e);
		if (e.kind == EVT_RESET || e.kind == EVT_SWTRAP) begin
			g.src = '0;
			e.src = '0;
		end
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wait_rdy(ref logic r);
		logic seen;
		do begin
			@(negedge aclk);
			seen = r;
			@(posedge aclk);
		end while (!seen);
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				wait_rdy(s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				wait_rdy(s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		wait_rdy(s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk_word(32'(bs_s), a < 12'h1E0 ? 32'h0 : 32'h2);
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wait_rdy(s_axi_arready);
		s_axi_arvalid <= 1'b0;
		wait_rdy(s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk_word(rd_s, e);
		chk_word(32'(rs_s), a < 12'h1E0 ? 32'h0 : 32'h2);
		@(posedge aclk);
	endtask

	task automatic drain;
		int w;
		for (w = 0; w < 300 && exp_q.size() != 0; w++)
			@(posedge aclk);
		chk_word(exp_q.size(), 0);
	endtask

	task automatic tally_and_finish;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#300000;
		errors++;
		tally_and_finish;
	end

	initial begin
		exp_q.push_back(mk(EVT_RESET, 0, 0, 0));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(12'h008, 32'h0);
		axi_rd(12'hFFC, 32'h0);
		axi_wr(12'hFF0, 32'h1);
		drain;
		// Table rows first, then random sources with slow and quick acks.
		for (k = 0; k < 10; k++) begin
			i = k == 0 ? 54 : k == 1 ? 16 : k == 2 ? 34
				: $unsigned($random(seed)) % 56;
			lv = 1 + $unsigned($random(seed)) % 15;
			axi_wr(12'(256 + 4 * i), 32'h40 | lv);
			cpu_prio <= 4'($unsigned($random(seed)) % lv);
			ack_delay <= 4'($random(seed));
			src_req <= 56'h1 << i;
			exp_q.push_back(mk(EVT_INT, 16 + i, lv, i));
			@(posedge aclk);
			src_req <= '0;
			drain;
		end
		axi_wr(12'h114, 32'h46);
		cpu_prio <= 4'h6;
		src_req <= 56'h20;
		@(posedge aclk);
		src_req <= '0;
		repeat (8) @(posedge aclk);
		axi_rd(12'h114, 32'hC6);
		exp_q.push_back(mk(EVT_INT, 8'h15, 6, 5));
		cpu_prio <= 4'h5;
		drain;
		axi_wr(12'h10C, 32'h44);
		axi_wr(12'h124, 32'h49);
		cpu_prio <= 4'h0;
		src_req <= 56'h208;
		exp_q.push_back(mk(EVT_INT, 8'h19, 9, 9));
		exp_q.push_back(mk(EVT_INT, 8'h13, 4, 3));
		@(posedge aclk);
		src_req <= '0;
		drain;
		for (k = 0; k < 8; k++) begin
			ack_delay <= 4'($unsigned($random(seed)) % 8);
			if (k == 0)
				nmi_pin_n <= 1'b0;
			else
				hw_trap <= hw_trap_s'(8'h80 >> k);
			exp_q.push_back(mk(EVT_TRAP, k < 3 ? 2 * k + 2 : 10, 15, k));
			// The pin filter rejects short dips, so the pin stays low three
			// cycles until two synchroniser stages agree on the new level.
			repeat (k == 0 ? 3 : 1) @(posedge aclk);
			hw_trap <= '0;
			nmi_pin_n <= 1'b1;
			drain;
			axi_rd(12'h000, 32'h1 << k);
			axi_wr(12'h000, 32'hFF);
		end
		chk_word(32'(irq), 32'h0);
		axi_wr(12'h008, 32'hF);
		chk_word(32'(irq), 32'h1);
		axi_rd(12'h004, 32'h3);
		chk_word(32'(irq), 32'h0);
		for (k = 0; k < 6; k++) begin
			n = k == 0 ? 0 : k == 1 ? 127 : $unsigned($random(seed)) % 128;
			lv = $unsigned($random(seed)) % 16;
			cpu_prio <= 4'(lv);
			sw_trap_valid <= 1'b1;
			sw_trap_num <= 7'(n);
			exp_q.push_back(mk(EVT_SWTRAP, n, lv, 0));
			@(posedge aclk);
			sw_trap_valid <= 1'b0;
			drain;
		end
		for (k = 0; k < 2; k++) begin
			{sw_reset, wdt_overflow} <= k ? 2'b01 : 2'b10;
			exp_q.push_back(mk(EVT_RESET, 0, 0, 0));
			@(posedge aclk);
			{sw_reset, wdt_overflow} <= 2'b00;
			drain;
		end
		chk_word(32'(irq), 32'h1);
		axi_rd(12'h004, 32'hC);
		chk_word(32'(irq), 32'h0);
		// An interrupt raised inside a class B service must wait, while a
		// class A trap still breaks in ahead of it.
		axi_wr(12'h100, 32'h4F);
		cpu_prio <= 4'h0;
		ack_delay <= 4'h0;
		hw_trap <= hw_trap_s'(7'h10);
		exp_q.push_back(mk(EVT_TRAP, 10, 15, 3));
		exp_q.push_back(mk(EVT_TRAP, 4, 15, 1));
		exp_q.push_back(mk(EVT_INT, 16, 15, 0));
		@(posedge aclk);
		hw_trap <= '0;
		while (exp_q.size() > 2)
			@(posedge aclk);
		src_req <= 56'h1;
		@(posedge aclk);
		src_req <= '0;
		repeat (3) @(posedge aclk);
		hw_trap <= hw_trap_s'(7'h40);
		@(posedge aclk);
		hw_trap <= '0;
		drain;
		tally_and_finish;
	end
endmodule
